// ---- verilog/t1rx_pkg.sv ----
// constants and carrier types for the t1 receive line monitor
package t1rx_pkg;
    // frame geometry
    localparam logic [7:0] F_POS = 8'h00;
    localparam logic [7:0] LAST_BIT = 8'hc0;
    localparam logic [7:0] BIT_ONE = 8'h01;
    localparam logic [4:0] SF_LAST_FRAME = 5'h0b;
    localparam logic [4:0] ESF_LAST_FRAME = 5'h17;
    localparam logic [2:0] CH_LSB = 3'h7;
    localparam logic [2:0] CH_BIT2 = 3'h1;
    // per-frame masks, bit n belongs to frame counter value n
    localparam logic [23:0] SF_CHECK = 24'h000fff;
    localparam logic [23:0] SF_PATTERN = 24'h0003b1;
    localparam logic [23:0] ESF_FPS_MASK = 24'h888888;
    localparam logic [23:0] ESF_FPS_PAT = 24'h880800;
    localparam logic [23:0] ESF_CRC_MASK = 24'h222222;
    localparam logic [23:0] SF_SIG_MASK = 24'h000820;
    localparam logic [23:0] ESF_SIG_MASK = 24'h820820;
    localparam logic [23:0] SF_SEL_MASK = 24'h0001c7;
    localparam logic [23:0] ESF_SEL_MASK = 24'h03f03f;
    localparam logic [23:0] SF_MF_MASK = 24'h00003f;
    localparam logic [23:0] ESF_MF_MASK = 24'h000fff;
    localparam logic [23:0] SF_LINK_MASK = 24'h000aaa;
    localparam logic [23:0] ESF_LINK_MASK = 24'h555555;
    // framer thresholds
    localparam logic [7:0] SYNC_GOOD = 8'h0c;
    localparam int OOF_ERRS = 2;
    localparam logic [5:0] CRC_POLY = 6'h03;
    // carrier loss and yellow alarm
    localparam logic [7:0] ZERO_LIMIT = 8'hc0;
    localparam logic [7:0] DENS_LAST = 8'hbf;
    localparam logic [7:0] DENS_ONES = 8'h18;
    localparam logic [7:0] YEL_SF_FRAMES = 8'h10;
    localparam logic [15:0] YEL_ESF_PAT = 16'hff00;
    localparam logic [5:0] YEL_ESF_HOLD = 6'h20;
    // serial port
    localparam logic [2:0] BYTE_LAST = 3'h7;
    localparam logic [3:0] STATUS_ADDR = 4'h5;
    localparam logic [3:0] BURST_ADDR = 4'h0;
    localparam logic [1:0] RSVD_OK = 2'h0;
    localparam logic [3:0] STAT_PAD = 4'h0;

    typedef enum logic {T1RX_SEARCH, T1RX_SYNC} t1rx_frm_e;
    typedef enum logic [1:0] {T1RX_SP_CMD, T1RX_SP_READ, T1RX_SP_SKIP} t1rx_sp_e;

    typedef struct packed {
        logic burst;
        logic [1:0] rsvd;
        logic [3:0] addr;
        logic rd;
    } t1rx_cmd_s;

    typedef struct packed {
        logic esf;
        logic yellow;
        logic carrier;
        logic sync_loss;
    } t1rx_stat_s;
endpackage

// ---- verilog/t1rx_line_monitor.sv ----
// t1 receive framer, line monitors and serial status port
`timescale 1ns/1ns
module t1rx_line_monitor (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_rx_clk,
    input wire logic i_positive_rail,
    input wire logic i_negative_rail,
    input wire logic i_esf_mode,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_sdi,
    output logic o_yellow_alarm,
    output logic o_link_data,
    output logic o_link_clock,
    output logic o_channel_clock,
    output logic o_serial_data,
    output logic o_frame_sync,
    output logic o_multiframe_sync,
    output logic o_signaling_bits,
    output logic o_signaling_frame_flag,
    output logic o_signaling_select,
    output logic o_carrier_loss,
    output logic o_bipolar_violation,
    output logic o_frame_error,
    output logic o_sync_loss,
    output logic o_irq_n,
    output logic o_irq_oe_n,
    output logic o_sdo,
    output logic o_sdo_oe_n
);

////////////////////////////////////////////////////////////////////////
// receive clock domain

    logic esf_s1_reg;
    logic esf_reg;
    logic pos_reg;
    logic neg_reg;
    logic [7:0] bit_cnt_reg;
    logic [4:0] frame_cnt_reg;
    t1rx_pkg::t1rx_frm_e frm_reg;
    logic [7:0] good_cnt_reg;
    logic [3:0] err_hist_reg;
    logic last_pos_reg;
    logic mark_seen_reg;
    logic fdl_cap_reg;
    logic [5:0] crc_reg;
    logic [5:0] crc_prev_reg;
    logic [5:0] rx_crc_reg;
    logic crc_arm_reg;
    logic frame_b2_reg;
    logic [7:0] yel_cnt_reg;
    logic [15:0] fdl_sh_reg;
    logic [5:0] yel_hold_reg;
    logic [7:0] zero_run_reg;
    logic [7:0] win_cnt_reg;
    logic [7:0] ones_cnt_reg;

    logic line_bit;
    logic nrz;
    logic f_bit;
    logic [4:0] last_frame;
    logic [4:0] next_frame;
    logic [23:0] chk_mask;
    logic [23:0] chk_pat;
    logic [23:0] link_mask;
    logic f_checked;
    logic f_err;
    logic slip;
    logic [7:0] dpos;
    logic [2:0] ch_bit;
    logic bpv_now;
    logic [3:0] hist_next;
    logic crc_in;
    logic [5:0] crc_step;
    logic crc_err_now;
    logic [15:0] fdl_next;
    logic in_sync;

    // mode pin crosses into the line domain through two stages
    always_ff @(posedge i_rx_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            esf_s1_reg <= 1'b0;
            esf_reg <= 1'b0;
        end else begin
            esf_s1_reg <= i_esf_mode;
            esf_reg <= esf_s1_reg;
        end
    end

    // rails sampled half a bit early so the rising edge sees settled data
    always_ff @(negedge i_rx_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pos_reg <= 1'b0;
            neg_reg <= 1'b0;
        end else begin
            pos_reg <= i_positive_rail;
            neg_reg <= i_negative_rail;
        end
    end

    // both rails high is illegal bipolar, so it means tied rails carrying nrz
    assign line_bit = pos_reg | neg_reg;
    assign nrz = pos_reg & neg_reg;
    assign f_bit = (bit_cnt_reg == t1rx_pkg::F_POS);
    assign last_frame = esf_reg ? t1rx_pkg::ESF_LAST_FRAME : t1rx_pkg::SF_LAST_FRAME;
    assign next_frame = (frame_cnt_reg >= last_frame) ? 5'h00 : frame_cnt_reg + 5'h01;
    assign chk_mask = esf_reg ? t1rx_pkg::ESF_FPS_MASK : t1rx_pkg::SF_CHECK;
    assign chk_pat = esf_reg ? t1rx_pkg::ESF_FPS_PAT : t1rx_pkg::SF_PATTERN;
    assign link_mask = esf_reg ? t1rx_pkg::ESF_LINK_MASK : t1rx_pkg::SF_LINK_MASK;
    assign f_checked = f_bit && chk_mask[frame_cnt_reg];
    assign f_err = f_checked && (line_bit != chk_pat[frame_cnt_reg]);
    assign in_sync = (frm_reg == t1rx_pkg::T1RX_SYNC);
    assign slip = !in_sync && f_err;
    assign dpos = bit_cnt_reg - t1rx_pkg::BIT_ONE;
    assign ch_bit = dpos[2:0];
    assign bpv_now = !nrz && (pos_reg ^ neg_reg) && mark_seen_reg && (pos_reg == last_pos_reg);
    assign hist_next = {err_hist_reg[2:0], f_err};
    assign crc_in = f_bit ? 1'b1 : line_bit;
    assign crc_step = {crc_reg[4:0], 1'b0} ^ ({6{crc_in ^ crc_reg[5]}} & t1rx_pkg::CRC_POLY);
    assign crc_err_now = esf_reg && crc_arm_reg && f_bit && (frame_cnt_reg == t1rx_pkg::ESF_LAST_FRAME)
        && (rx_crc_reg != crc_prev_reg);
    assign fdl_next = {fdl_sh_reg[14:0], line_bit};

    // bit and frame position; a slip during search shifts the guess by one bit
    always_ff @(posedge i_rx_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bit_cnt_reg <= t1rx_pkg::F_POS;
            frame_cnt_reg <= 5'h00;
        end else if (slip) begin
            bit_cnt_reg <= bit_cnt_reg;
        end else if (bit_cnt_reg == t1rx_pkg::LAST_BIT) begin
            bit_cnt_reg <= t1rx_pkg::F_POS;
            frame_cnt_reg <= next_frame;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + t1rx_pkg::BIT_ONE;
        end
    end

    // framer: search until enough good f-bits, lose sync on 2 errors in 4
    always_ff @(posedge i_rx_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            frm_reg <= t1rx_pkg::T1RX_SEARCH;
            good_cnt_reg <= 8'h00;
            err_hist_reg <= 4'h0;
        end else if (f_checked) begin
            unique case (frm_reg)
                t1rx_pkg::T1RX_SEARCH: begin
                    if (f_err) begin
                        good_cnt_reg <= 8'h00;
                    end else if (good_cnt_reg == t1rx_pkg::SYNC_GOOD) begin
                        frm_reg <= t1rx_pkg::T1RX_SYNC;
                        err_hist_reg <= 4'h0;
                    end else begin
                        good_cnt_reg <= good_cnt_reg + 8'h01;
                    end
                end
                t1rx_pkg::T1RX_SYNC: begin
                    err_hist_reg <= hist_next;
                    if ($countones(hist_next) >= t1rx_pkg::OOF_ERRS) begin
                        frm_reg <= t1rx_pkg::T1RX_SEARCH;
                        good_cnt_reg <= 8'h00;
                    end
                end
            endcase
        end
    end

    // data, timing and flag outputs, all registered on the same edge
    always_ff @(posedge i_rx_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_serial_data <= 1'b0;
            o_frame_sync <= 1'b0;
            o_channel_clock <= 1'b0;
            o_multiframe_sync <= 1'b0;
            o_signaling_frame_flag <= 1'b0;
            o_signaling_select <= 1'b0;
            o_sync_loss <= 1'b1;
            o_frame_error <= 1'b0;
            o_bipolar_violation <= 1'b0;
        end else begin
            o_serial_data <= line_bit;
            // a search slip repeats the f position; suppress it on the slipping clock so the pulse stays one clock
            o_frame_sync <= f_bit && !slip;
            o_channel_clock <= !f_bit && !ch_bit[2];
            if (!slip) begin
                o_multiframe_sync <= esf_reg ? t1rx_pkg::ESF_MF_MASK[frame_cnt_reg]
                    : t1rx_pkg::SF_MF_MASK[frame_cnt_reg];
            end
            o_signaling_frame_flag <= in_sync && (esf_reg ? t1rx_pkg::ESF_SIG_MASK[frame_cnt_reg]
                : t1rx_pkg::SF_SIG_MASK[frame_cnt_reg]);
            o_signaling_select <= esf_reg ? t1rx_pkg::ESF_SEL_MASK[frame_cnt_reg]
                : t1rx_pkg::SF_SEL_MASK[frame_cnt_reg];
            o_sync_loss <= !in_sync;
            o_frame_error <= in_sync && (f_err || crc_err_now);
            o_bipolar_violation <= bpv_now;
        end
    end

    // last mark polarity for violation checks; nrz marks are not tracked
    always_ff @(posedge i_rx_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            last_pos_reg <= 1'b0;
            mark_seen_reg <= 1'b0;
        end else if (!nrz && (pos_reg ^ neg_reg)) begin
            last_pos_reg <= pos_reg;
            mark_seen_reg <= 1'b1;
        end
    end

    // robbed bit sits in each channel lsb, so the same tap serves both frame kinds
    always_ff @(posedge i_rx_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_signaling_bits <= 1'b0;
        end else if (!f_bit && ch_bit == t1rx_pkg::CH_LSB) begin
            o_signaling_bits <= line_bit;
        end
    end

    // link bit captured at its f-bit, presented at the end of the frame before the next link frame
    always_ff @(posedge i_rx_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fdl_cap_reg <= 1'b0;
            o_link_data <= 1'b0;
            o_link_clock <= 1'b0;
        end else begin
            if (f_bit && link_mask[frame_cnt_reg]) begin
                fdl_cap_reg <= line_bit;
            end
            // frame timing is only a guess in search, so the link outputs hold until sync
            if (bit_cnt_reg == t1rx_pkg::LAST_BIT && in_sync) begin
                if (link_mask[next_frame]) begin
                    o_link_data <= fdl_cap_reg;
                end
                o_link_clock <= link_mask[next_frame];
            end
        end
    end

    // crc-6 over each multiframe with f-bits as ones, checked against the next one
    always_ff @(posedge i_rx_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            crc_reg <= 6'h00;
            crc_prev_reg <= 6'h00;
            rx_crc_reg <= 6'h00;
            crc_arm_reg <= 1'b0;
        end else begin
            if (f_bit && frame_cnt_reg == 5'h00) begin
                crc_prev_reg <= crc_reg;
                crc_reg <= t1rx_pkg::CRC_POLY;
                crc_arm_reg <= in_sync && esf_reg;
            end else begin
                crc_reg <= crc_step;
            end
            if (f_bit && esf_reg && t1rx_pkg::ESF_CRC_MASK[frame_cnt_reg]) begin
                rx_crc_reg <= {rx_crc_reg[4:0], line_bit};
            end
        end
    end

    // yellow: bit 2 low in all channels (sf) or ff00 pattern on the link (esf)
    always_ff @(posedge i_rx_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            frame_b2_reg <= 1'b0;
            yel_cnt_reg <= 8'h00;
            fdl_sh_reg <= 16'h0000;
            yel_hold_reg <= 6'h00;
            o_yellow_alarm <= 1'b0;
        end else if (!in_sync) begin
            frame_b2_reg <= 1'b0;
            yel_cnt_reg <= 8'h00;
            yel_hold_reg <= 6'h00;
            o_yellow_alarm <= 1'b0;
        end else if (esf_reg) begin
            if (f_bit && link_mask[frame_cnt_reg]) begin
                fdl_sh_reg <= fdl_next;
                if (fdl_next == t1rx_pkg::YEL_ESF_PAT) begin
                    yel_hold_reg <= 6'h00;
                    o_yellow_alarm <= 1'b1;
                end else if (yel_hold_reg == t1rx_pkg::YEL_ESF_HOLD) begin
                    o_yellow_alarm <= 1'b0;
                end else begin
                    yel_hold_reg <= yel_hold_reg + 6'h01;
                end
            end
        end else if (f_bit) begin
            frame_b2_reg <= 1'b0;
            if (frame_b2_reg) begin
                yel_cnt_reg <= 8'h00;
                o_yellow_alarm <= 1'b0;
            end else if (yel_cnt_reg == t1rx_pkg::YEL_SF_FRAMES) begin
                o_yellow_alarm <= 1'b1;
            end else begin
                yel_cnt_reg <= yel_cnt_reg + 8'h01;
            end
        end else if (ch_bit == t1rx_pkg::CH_BIT2) begin
            frame_b2_reg <= frame_b2_reg | line_bit;
        end
    end

    // carrier loss: zero run sets it, a window at 12.5% ones clears it
    always_ff @(posedge i_rx_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            zero_run_reg <= 8'h00;
            win_cnt_reg <= 8'h00;
            ones_cnt_reg <= 8'h00;
            o_carrier_loss <= 1'b0;
        end else begin
            if (line_bit) begin
                zero_run_reg <= 8'h00;
            end else if (zero_run_reg != t1rx_pkg::ZERO_LIMIT) begin
                zero_run_reg <= zero_run_reg + 8'h01;
            end
            if (win_cnt_reg == t1rx_pkg::DENS_LAST) begin
                win_cnt_reg <= 8'h00;
                ones_cnt_reg <= 8'h00;
            end else begin
                win_cnt_reg <= win_cnt_reg + 8'h01;
                ones_cnt_reg <= ones_cnt_reg + {7'h00, line_bit};
            end
            if (zero_run_reg == t1rx_pkg::ZERO_LIMIT) begin
                o_carrier_loss <= 1'b1;
            end else if (win_cnt_reg == t1rx_pkg::DENS_LAST
                && (ones_cnt_reg + {7'h00, line_bit}) >= t1rx_pkg::DENS_ONES) begin
                o_carrier_loss <= 1'b0;
            end
        end
    end

////////////////////////////////////////////////////////////////////////
// system clock domain: status crossing, interrupt, serial port

    t1rx_pkg::t1rx_stat_s stat_rx;
    t1rx_pkg::t1rx_stat_s stat_s1_reg;
    t1rx_pkg::t1rx_stat_s stat_reg;
    logic sclk_s1_reg;
    logic sclk_s2_reg;
    logic sclk_d_reg;
    logic cs_s1_reg;
    logic cs_s2_reg;
    logic sdi_s1_reg;
    logic sdi_s2_reg;
    t1rx_pkg::t1rx_sp_e sp_reg;
    logic [7:0] sh_reg;
    logic [2:0] cnt_reg;
    logic [3:0] addr_reg;
    logic burst_reg;
    logic [7:0] rd_sh_reg;
    logic sclk_rise;
    logic sclk_fall;
    t1rx_pkg::t1rx_cmd_s cmd_next;
    logic [3:0] addr_inc;

    // each status bit is an independent slow level, so two stages suffice
    assign stat_rx = '{esf: esf_reg, yellow: o_yellow_alarm, carrier: o_carrier_loss, sync_loss: o_sync_loss};

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stat_s1_reg <= '0;
            stat_reg <= '0;
        end else begin
            stat_s1_reg <= stat_rx;
            stat_reg <= stat_s1_reg;
        end
    end

    // open drain: enable the low drive while any alarm stands
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_n <= 1'b0;
            o_irq_oe_n <= 1'b1;
        end else begin
            o_irq_n <= 1'b0;
            o_irq_oe_n <= !(stat_reg.yellow || stat_reg.carrier || stat_reg.sync_loss);
        end
    end

    // port pins are asynchronous; serial clock must stay well below a quarter of the system clock
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_d_reg <= 1'b0;
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            sdi_s1_reg <= 1'b0;
            sdi_s2_reg <= 1'b0;
        end else begin
            sclk_s1_reg <= i_sclk;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_d_reg <= sclk_s2_reg;
            cs_s1_reg <= i_cs_n;
            cs_s2_reg <= cs_s1_reg;
            sdi_s1_reg <= i_sdi;
            sdi_s2_reg <= sdi_s1_reg;
        end
    end

    assign sclk_rise = sclk_s2_reg && !sclk_d_reg;
    assign sclk_fall = !sclk_s2_reg && sclk_d_reg;
    assign cmd_next = t1rx_pkg::t1rx_cmd_s'({sdi_s2_reg, sh_reg[7:1]});
    assign addr_inc = addr_reg + 4'h1;

    // only the status address returns data; other addresses read as zero
    function automatic logic [7:0] rd_value(input logic [3:0] a, input t1rx_pkg::t1rx_stat_s s);
        rd_value = (a == t1rx_pkg::STATUS_ADDR) ? {t1rx_pkg::STAT_PAD, s} : 8'h00;
    endfunction

    // serial transfer: command byte, then lsb-first data; writes are discarded
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sp_reg <= t1rx_pkg::T1RX_SP_CMD;
            sh_reg <= 8'h00;
            cnt_reg <= 3'h0;
            addr_reg <= 4'h0;
            burst_reg <= 1'b0;
            rd_sh_reg <= 8'h00;
            o_sdo <= 1'b0;
            o_sdo_oe_n <= 1'b1;
        end else if (cs_s2_reg) begin
            sp_reg <= t1rx_pkg::T1RX_SP_CMD;
            cnt_reg <= 3'h0;
            o_sdo_oe_n <= 1'b1;
        end else begin
            unique case (sp_reg)
                t1rx_pkg::T1RX_SP_CMD: begin
                    if (sclk_rise) begin
                        sh_reg <= cmd_next;
                        cnt_reg <= cnt_reg + 3'h1;
                        if (cnt_reg == t1rx_pkg::BYTE_LAST) begin
                            addr_reg <= cmd_next.addr;
                            burst_reg <= cmd_next.burst && (cmd_next.addr == t1rx_pkg::BURST_ADDR);
                            rd_sh_reg <= rd_value(cmd_next.addr, stat_reg);
                            if (cmd_next.rd && cmd_next.rsvd == t1rx_pkg::RSVD_OK) begin
                                sp_reg <= t1rx_pkg::T1RX_SP_READ;
                            end else begin
                                sp_reg <= t1rx_pkg::T1RX_SP_SKIP;
                            end
                        end
                    end
                end
                t1rx_pkg::T1RX_SP_READ: begin
                    if (sclk_fall) begin
                        o_sdo <= rd_sh_reg[0];
                        o_sdo_oe_n <= 1'b0;
                        rd_sh_reg <= {1'b0, rd_sh_reg[7:1]};
                        cnt_reg <= cnt_reg + 3'h1;
                        if (cnt_reg == t1rx_pkg::BYTE_LAST) begin
                            if (burst_reg) begin
                                addr_reg <= addr_inc;
                                rd_sh_reg <= rd_value(addr_inc, stat_reg);
                            end else begin
                                sp_reg <= t1rx_pkg::T1RX_SP_SKIP;
                            end
                        end
                    end
                end
                t1rx_pkg::T1RX_SP_SKIP: begin
                    if (sclk_fall) begin
                        o_sdo_oe_n <= 1'b1;
                    end
                end
            endcase
        end
    end

endmodule // t1rx_line_monitor

// ---- bench/t1rx_line_monitor_props.sv ----
// assertion checker for the t1 receive line monitor ports
`timescale 1ns/1ns
module t1rx_line_monitor_props (
    input wire logic i_rst_n,
    input wire logic i_rx_clk,
    input wire logic o_frame_sync,
    input wire logic o_channel_clock,
    input wire logic o_multiframe_sync,
    input wire logic o_link_clock,
    input wire logic o_signaling_frame_flag,
    input wire logic o_frame_error,
    input wire logic o_sync_loss,
    input wire logic o_irq_oe_n
);
    // all on the line clock; the interrupt crosses domains, hence its wide bound
    default clocking dclk @(posedge i_rx_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////
    fs_width_a: assert property (o_frame_sync |=> !o_frame_sync) else $error("fsync width");
    fs_period_a: assert property (o_frame_sync && !o_sync_loss |-> ##193 (o_frame_sync || o_sync_loss))
        else $error("fsync period");
    ch_slots_a: assert property (
        o_frame_sync |-> !o_channel_clock ##1 o_channel_clock[*4] ##1 !o_channel_clock[*4]) else $error("chclk slot");
    mf_rise_a: assert property ($rose(o_multiframe_sync) |-> o_frame_sync) else $error("msync edge");
    link_edge_a: assert property ($changed(o_link_clock) |=> o_frame_sync) else $error("link update");
    fer_sync_a: assert property (o_frame_error |-> o_frame_sync && !o_sync_loss) else $error("ferr timing");
    sigfr_sync_a: assert property (o_signaling_frame_flag |-> !o_sync_loss) else $error("sigfr in search");
    irq_alarm_a: assert property (o_sync_loss |-> ##[0:8] !o_irq_oe_n) else $error("irq missing");
    lock_c: cover property ($fell(o_sync_loss));
    ferr_c: cover property (o_frame_error);
    alarm_c: cover property ($fell(o_irq_oe_n));
endmodule // t1rx_line_monitor_props
bind t1rx_line_monitor t1rx_line_monitor_props u_props (.i_rst_n, .i_rx_clk, .o_frame_sync, .o_channel_clock,
    .o_multiframe_sync, .o_link_clock, .o_signaling_frame_flag, .o_frame_error, .o_sync_loss, .o_irq_oe_n);

// ---- bench/t1rx_line_src.sv ----
// line-side partner: free running receive clock and ami superframe stream
`timescale 1ns/1ns
module t1rx_line_src (
    input wire logic i_rst_n,
    input wire logic i_zeros,
    output logic o_rx_clk = 1'b0,
    output logic o_pos = 1'b0,
    output logic o_neg = 1'b0
);
    logic [7:0] bit_cnt = 8'h00;
    logic [3:0] frm_cnt = 4'h0;
    logic pol = 1'b0;
    // line clock, phase offset so it never lines up with the system clock
    initial begin
        #37;
        forever #80 o_rx_clk = ~o_rx_clk;
    end
    // ami launched on the rising edge so the falling-edge sample sees settled rails
    always @(posedge o_rx_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bit_cnt <= 8'h00;
            frm_cnt <= 4'h0;
        end else begin
            o_pos <= !i_zeros && (bit_cnt != 8'h00 || t1rx_pkg::SF_PATTERN[frm_cnt]) && !pol;
            o_neg <= !i_zeros && (bit_cnt != 8'h00 || t1rx_pkg::SF_PATTERN[frm_cnt]) && pol;
            pol <= pol ^ (!i_zeros && (bit_cnt != 8'h00 || t1rx_pkg::SF_PATTERN[frm_cnt]));
            bit_cnt <= (bit_cnt == t1rx_pkg::LAST_BIT) ? 8'h00 : bit_cnt + 8'h01;
            if (bit_cnt == t1rx_pkg::LAST_BIT) frm_cnt <= (frm_cnt == 4'hb) ? 4'h0 : frm_cnt + 4'h1;
        end
    end
endmodule // t1rx_line_src

// ---- bench/t1rx_line_monitor_tb_top.sv ----
// self-checking bench for the t1 receive line monitor
`timescale 1ns/1ns
module t1rx_line_monitor_tb_top;
    logic i_sys_clk = 1'b0, i_rx_clk, i_positive_rail, i_negative_rail, drv, o_irq_n, o_sdo, o_sdo_oe_n;
    logic i_rst_n = 1'b0, i_cs_n = 1'b1, i_sclk = 1'b1, i_sdi = 1'b0, zeros = 1'b0, i_esf_mode = 1'b0;
    logic o_yellow_alarm, o_link_data, o_link_clock, o_channel_clock, o_serial_data, o_frame_sync, o_irq_oe_n;
    logic o_multiframe_sync, o_signaling_bits, o_signaling_frame_flag, o_signaling_select, o_carrier_loss;
    logic o_bipolar_violation, o_frame_error, o_sync_loss;
    logic [7:0] rd;
    int errors = 0, n_tests = 0;
    t1rx_line_monitor u_t1rx_line_monitor (.i_sys_clk, .i_rst_n, .i_rx_clk, .i_positive_rail, .i_negative_rail,
        .i_esf_mode, .i_sclk, .i_cs_n, .i_sdi, .o_yellow_alarm, .o_link_data, .o_link_clock, .o_channel_clock,
        .o_serial_data, .o_frame_sync, .o_multiframe_sync, .o_signaling_bits, .o_signaling_frame_flag,
        .o_signaling_select, .o_carrier_loss, .o_bipolar_violation, .o_frame_error, .o_sync_loss, .o_irq_n,
        .o_irq_oe_n, .o_sdo, .o_sdo_oe_n);
    t1rx_line_src u_t1rx_line_src (.i_rst_n, .i_zeros(zeros), .o_rx_clk(i_rx_clk), .o_pos(i_positive_rail),
        .o_neg(i_negative_rail));
    ////////////////////////////////////////
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // host transfer: sdi moves in the low phase, sdo is taken just before each rise of the data byte
    task sp(input logic [7:0] cmd);
        drv = 1'b0;
        i_cs_n <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            i_sclk <= 1'b0;
            i_sdi <= cmd[i % 8];
            repeat (6) @(posedge i_sys_clk);
            if (i > 7) rd[i - 8] = o_sdo;
            if (i > 7) drv = drv | !o_sdo_oe_n;
            i_sclk <= 1'b1;
            repeat (6) @(posedge i_sys_clk);
        end
        i_cs_n <= 1'b1;
        repeat (10) @(posedge i_sys_clk);
    endtask
    // bounded wait for lock; a slow search shows up as a failed compare afterwards
    task wait_sync;
        for (int k = 0; k < 20000 && o_sync_loss !== 1'b0; k++) @(posedge i_sys_clk);
        repeat (20) @(posedge i_sys_clk);
    endtask
    task t_lock_read;
        chk("sync_loss_rst", 8'h01, {7'h00, o_sync_loss});
        chk("irq_oe_n_rst", 8'h01, {7'h00, o_irq_oe_n});
        i_rst_n <= 1'b1;
        wait_sync;
        chk("sync_loss", 8'h00, {7'h00, o_sync_loss});
        chk("irq_oe_n", 8'h01, {7'h00, o_irq_oe_n});
        chk("irq_n", 8'h00, {7'h00, o_irq_n});
        chk("sig_bits", 8'h01, {7'h00, o_signaling_bits});
        chk("carrier_ok", 8'h00, {7'h00, o_carrier_loss});
        chk("yellow_ok", 8'h00, {7'h00, o_yellow_alarm});
        chk("bpv_ok", 8'h00, {7'h00, o_bipolar_violation});
        sp(8'h0b);
        chk("status", 8'h00, rd);
        chk("sdo_read", 8'h01, {7'h00, drv});
        sp(8'h0a);
        chk("sdo_write", 8'h00, {7'h00, drv});
        $display("test lock_read done");
    endtask
    task t_resync;
        i_rst_n <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        repeat (20) @(posedge i_sys_clk);
        chk("sync_loss_pulse", 8'h01, {7'h00, o_sync_loss});
        wait_sync;
        chk("sync_relock", 8'h00, {7'h00, o_sync_loss});
        $display("test resync done");
    endtask
    task t_zeros;
        zeros <= 1'b1;
        repeat (2000) @(posedge i_sys_clk);
        chk("carrier_set", 8'h01, {7'h00, o_carrier_loss});
        chk("irq_oe_n_alarm", 8'h00, {7'h00, o_irq_oe_n});
        sp(8'h0b);
        chk("status_alarm", 8'h03, rd);
        zeros <= 1'b0;
        repeat (700) @(posedge i_sys_clk);
        chk("carrier_clear", 8'h00, {7'h00, o_carrier_loss});
        $display("test zeros done");
    endtask
    initial forever #50 i_sys_clk = ~i_sys_clk;
    // watchdog well beyond two frame searches plus the carrier test
    initial begin
        repeat (40000) @(posedge i_sys_clk);
        errors++;
        results;
    end
    initial begin
        repeat (10) @(posedge i_sys_clk);
        t_lock_read;
        t_resync;
        t_zeros;
        results;
    end
endmodule // t1rx_line_monitor_tb_top
